/* File: hdl/eieu_map.svh */
`ifndef EIEU_MAP_SVH
`define EIEU_MAP_SVH

// Register indices; byte address is four times the index
`define EIEU_IDX_FLAG 6'h04
`define EIEU_IDX_ENABLE 6'h05
`define EIEU_IDX_POLARITY 6'h0c
`define EIEU_IDX_STATUS 6'h0d
`define EIEU_IDX_MASK 6'h0e

// Index field of a byte address
`define EIEU_IDX_HI 7
`define EIEU_IDX_LO 2

`define EIEU_RST_FLAG 8'h00
`define EIEU_RST_ENABLE 8'h00
`define EIEU_RST_POLARITY 8'h00
`define EIEU_RST_STATUS 8'h00
`define EIEU_RST_MASK 8'h00

`define EIEU_RESP_OKAY 2'h0
`define EIEU_RESP_SLVERR 2'h2

`endif

/* File: hdl/eieu_pkg.sv */
package eieu_pkg;

   localparam int LINES = 8;

   typedef logic [LINES-1:0] eieu_line_t;
   typedef logic [1:0] eieu_resp_t;
   typedef logic [7:0] eieu_addr_t;
   typedef logic [31:0] eieu_data_t;
   typedef logic [3:0] eieu_strb_t;

endpackage : eieu_pkg

/* File: hdl/eieu_top.sv */
// Contract
// RULE_01 - Lines 2 to 7 flag a falling pin edge when their polarity bit is 1, a rising one when 0.
// RULE_02 - A request goes to the core whenever a flag and its matching enable are both 1.
// RULE_03 - A flag stays 1 until software writes 0 or reset; later edges never clear or toggle it.
// RULE_04 - The service routine must clear the flag before returning, or the request persists.
// RULE_05 - Enable bit n lets line n request when 1 and blocks it when 0.
// RULE_06 - Every reset forces the enable register to zero so all lines start disabled.
// RULE_07 - Lines 0 and 1 detect edges and set flags exactly like lines 2 to 7.
// RULE_08 - Every reset clears the flag register; flag bit n belongs to line n.
// RULE_09 - The request is the OR of flag AND enable over all lines; pins are synchronised first.
//
// Our own choice: the AXI4-Lite register port.
`include "eieu_map.svh"
`timescale 1ns/1ps
`default_nettype none

module eieu_top
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire eieu_pkg::eieu_line_t ext_int_pin,
   output logic ext_irq_req,
   output logic irq,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire eieu_pkg::eieu_addr_t s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire eieu_pkg::eieu_data_t s_axi_wdata,
   input wire eieu_pkg::eieu_strb_t s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output eieu_pkg::eieu_resp_t s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire eieu_pkg::eieu_addr_t s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output eieu_pkg::eieu_data_t s_axi_rdata,
   output eieu_pkg::eieu_resp_t s_axi_rresp
);
   import eieu_pkg::*;

   eieu_line_t sync1_reg, sync2_reg, prev_reg;
   eieu_line_t flag_reg, flag_next, enable_reg, enable_next, polarity_reg;
   eieu_line_t status_reg, status_next, mask_reg, edge_hit;

   logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
   logic awready_reg, wready_reg, bvalid_reg, bvalid_next;
   logic arready_reg, rvalid_reg, rvalid_next;
   eieu_addr_t aw_addr_reg;
   eieu_data_t wdata_reg, rdata_reg;
   logic wlane0_reg;
   eieu_resp_t bresp_reg, rresp_reg;
   logic req_reg, irq_reg;

   // Pin synchroniser; only sync2 and later stages feed logic
   always_ff @(posedge core_clk)
   begin
      sync1_reg <= ext_int_pin; // RULE_09
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
   end

   genvar g;
   generate
      for (g = 0; g < LINES; g++)
      begin : g_edge
         // Polarity 1 picks the falling edge, 0 the rising edge
         assign edge_hit[g] = polarity_reg[g] ? (prev_reg[g] & ~sync2_reg[g])
                                              : (~prev_reg[g] & sync2_reg[g]); // RULE_01 RULE_07
      end
   endgenerate

   // Write channel
   wire do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
   wire aw_take = s_axi_awvalid & awready_reg;
   wire w_take = s_axi_wvalid & wready_reg;
   wire [5:0] wr_idx = aw_addr_reg[`EIEU_IDX_HI:`EIEU_IDX_LO];
   wire wr_flag = do_write & wlane0_reg & (wr_idx == `EIEU_IDX_FLAG);
   wire wr_enable = do_write & wlane0_reg & (wr_idx == `EIEU_IDX_ENABLE);
   wire wr_polarity = do_write & wlane0_reg & (wr_idx == `EIEU_IDX_POLARITY);
   wire wr_mask = do_write & wlane0_reg & (wr_idx == `EIEU_IDX_MASK);
   wire wr_mapped = (wr_idx == `EIEU_IDX_FLAG) | (wr_idx == `EIEU_IDX_ENABLE)
                  | (wr_idx == `EIEU_IDX_POLARITY) | (wr_idx == `EIEU_IDX_STATUS)
                  | (wr_idx == `EIEU_IDX_MASK);

   assign aw_full_next = aw_full_reg ? ~do_write : aw_take;
   assign w_full_next = w_full_reg ? ~do_write : w_take;
   assign bvalid_next = bvalid_reg ? ~s_axi_bready : do_write;

   // Read channel
   wire ar_take = s_axi_arvalid & arready_reg;
   wire [5:0] rd_idx = s_axi_araddr[`EIEU_IDX_HI:`EIEU_IDX_LO];
   wire rd_flag = rd_idx == `EIEU_IDX_FLAG;
   wire rd_enable = rd_idx == `EIEU_IDX_ENABLE;
   wire rd_polarity = rd_idx == `EIEU_IDX_POLARITY;
   wire rd_status = rd_idx == `EIEU_IDX_STATUS;
   wire rd_mask = rd_idx == `EIEU_IDX_MASK;
   wire rd_mapped = rd_flag | rd_enable | rd_polarity | rd_status | rd_mask;
   wire [7:0] rd_byte = ({8{rd_flag}} & flag_reg) | ({8{rd_enable}} & enable_reg)
                      | ({8{rd_polarity}} & polarity_reg) | ({8{rd_status}} & status_reg)
                      | ({8{rd_mask}} & mask_reg);
   assign rvalid_next = rvalid_reg ? ~s_axi_rready : ar_take;

   // A new edge in the cycle of a clearing write still leaves the flag set
   assign flag_next = (wr_flag ? wdata_reg[LINES-1:0] : flag_reg) | edge_hit; // RULE_03
   assign enable_next = wr_enable ? wdata_reg[LINES-1:0] : enable_reg; // RULE_05
   // Status read-clear loses to a same-cycle edge
   assign status_next = ((ar_take & rd_status) ? '0 : status_reg) | edge_hit;

   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         flag_reg <= `EIEU_RST_FLAG; // RULE_08
         enable_reg <= `EIEU_RST_ENABLE; // RULE_06
         polarity_reg <= `EIEU_RST_POLARITY;
         status_reg <= `EIEU_RST_STATUS;
         mask_reg <= `EIEU_RST_MASK;
         req_reg <= 1'b0;
         irq_reg <= 1'b0;
      end
      else
      begin
         flag_reg <= flag_next;
         enable_reg <= enable_next;
         if (wr_polarity)
            polarity_reg <= wdata_reg[LINES-1:0];
         status_reg <= status_next;
         if (wr_mask)
            mask_reg <= wdata_reg[LINES-1:0];
         // Built from next values so the request matches the registers cycle for cycle
         req_reg <= |(flag_next & enable_next); // RULE_02 RULE_09
         irq_reg <= |(status_next & (wr_mask ? wdata_reg[LINES-1:0] : mask_reg));
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= `EIEU_RESP_OKAY;
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rresp_reg <= `EIEU_RESP_OKAY;
         rdata_reg <= '0;
         aw_addr_reg <= '0;
         wdata_reg <= '0;
         wlane0_reg <= 1'b0;
      end
      else
      begin
         aw_full_reg <= aw_full_next;
         w_full_reg <= w_full_next;
         bvalid_reg <= bvalid_next;
         rvalid_reg <= rvalid_next;
         // One write and one read in flight; ready drops while a slot is held
         awready_reg <= ~aw_full_next & ~bvalid_next;
         wready_reg <= ~w_full_next & ~bvalid_next;
         arready_reg <= ~rvalid_next;
         if (aw_take)
            aw_addr_reg <= s_axi_awaddr;
         if (w_take)
         begin
            wdata_reg <= s_axi_wdata;
            wlane0_reg <= s_axi_wstrb[0];
         end
         if (do_write)
            bresp_reg <= wr_mapped ? `EIEU_RESP_OKAY : `EIEU_RESP_SLVERR;
         if (ar_take)
         begin
            rdata_reg <= {24'h000000, rd_byte};
            rresp_reg <= rd_mapped ? `EIEU_RESP_OKAY : `EIEU_RESP_SLVERR;
         end
      end
   end

   assign ext_irq_req = req_reg;
   assign irq = irq_reg;
   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   sequence fall_s(logic p, logic c);
      p && !c;
   endsequence

   sequence rise_s(logic p, logic c);
      !p && c;
   endsequence

   generate
      for (g = 0; g < LINES; g++)
      begin : g_chk
         falling_edge_sets_a: assert property (@(posedge core_clk) disable iff (!rstn) // RULE_01
            (polarity_reg[g] and fall_s(prev_reg[g], sync2_reg[g])) |=> flag_reg[g])
            else $error("falling edge did not set flag");
         rising_edge_sets_a: assert property (@(posedge core_clk) disable iff (!rstn) // RULE_07
            (!polarity_reg[g] and rise_s(prev_reg[g], sync2_reg[g])) |=> flag_reg[g])
            else $error("rising edge did not set flag");
      end
   endgenerate

   flag_sticky_a: assert property (@(posedge core_clk) disable iff (!rstn) // RULE_03
      !wr_flag |=> ((flag_reg & $past(flag_reg)) == $past(flag_reg)))
      else $error("flag dropped without a write");

   req_raised_a: assert property (@(posedge core_clk) disable iff (!rstn) // RULE_02
      (|(flag_reg & enable_reg)) |-> ext_irq_req)
      else $error("request missing for enabled flag");

   enable_blocks_a: assert property (@(posedge core_clk) disable iff (!rstn) // RULE_05
      ext_irq_req |-> (|(flag_reg & enable_reg)))
      else $error("request without enabled flag");

   enable_reset_a: assert property (@(posedge core_clk) disable iff (!rstn) // RULE_06
      $rose(rstn) |-> (enable_reg == `EIEU_RST_ENABLE) && !ext_irq_req)
      else $error("enable not cleared by reset");

   flag_reset_a: assert property (@(posedge core_clk) disable iff (!rstn) // RULE_08
      $rose(rstn) |-> (flag_reg == `EIEU_RST_FLAG))
      else $error("flag not cleared by reset");

   pin_sync_a: assert property (@(posedge core_clk) disable iff (!rstn) // RULE_09
      $rose(rstn) ##2 1'b1 |-> (sync2_reg == $past(ext_int_pin, 2)))
      else $error("pin synchroniser depth wrong");

endmodule : eieu_top

`default_nettype wire

/* File: bench/eieu_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module eieu_core_model
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic ext_irq_req,
   output var int req_seen
);
   logic req_d;
   // Core enters service once per rising request; a request held high is counted only once
   always_ff @(posedge core_clk)
   begin
      req_d <= ext_irq_req;
      if (!rstn)
         req_seen <= 0;
      else if (ext_irq_req && !req_d)
         req_seen <= req_seen + 1;
   end
endmodule : eieu_core_model
`default_nettype wire

/* File: bench/external_interrupt_edge_unit_test.sv */
`include "eieu_map.svh"
`timescale 1ns/1ps
`default_nettype none
module external_interrupt_edge_unit_test import eieu_pkg::*;;
   localparam eieu_addr_t a_flag = {`EIEU_IDX_FLAG, 2'b00};
   localparam eieu_addr_t a_en = {`EIEU_IDX_ENABLE, 2'b00};
   localparam eieu_addr_t a_pol = {`EIEU_IDX_POLARITY, 2'b00};
   localparam eieu_addr_t a_st = {`EIEU_IDX_STATUS, 2'b00};
   localparam eieu_addr_t a_mask = {`EIEU_IDX_MASK, 2'b00};
   logic core_clk = 0, rstn = 0, irq, ext_irq_req;
   eieu_line_t ext_int_pin = '0;
   logic awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0;
   logic arvalid = 0, arready, rvalid, rready = 0;
   eieu_addr_t awaddr = '0, araddr = '0;
   eieu_data_t wdata = '0, rdata;
   eieu_strb_t wstrb = 4'hf;
   eieu_resp_t bresp, rresp;
   int err_total = 0, n_tests = 0, req_seen;
   always #4 core_clk = ~core_clk;
   eieu_top uut (.core_clk(core_clk), .rstn(rstn), .ext_int_pin(ext_int_pin),
      .ext_irq_req(ext_irq_req), .irq(irq), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));
   eieu_core_model core (.core_clk(core_clk), .rstn(rstn), .ext_irq_req(ext_irq_req),
      .req_seen(req_seen));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input eieu_addr_t a, input eieu_data_t d, input eieu_resp_t er);
      logic aw_ok, w_ok;
      aw_ok = 0;
      w_ok = 0;
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      while (!(aw_ok && w_ok))
      begin
         @(posedge core_clk);
         if (awvalid && awready)
         begin
            aw_ok = 1;
            awvalid <= 0;
         end
         if (wvalid && wready)
         begin
            w_ok = 1;
            wvalid <= 0;
         end
      end
      do @(posedge core_clk); while (bvalid !== 1'b1);
      bready <= 0;
      chk("bresp", {30'h0, er}, {30'h0, bresp});
   endtask : wr
   task automatic rd(input eieu_addr_t a, input eieu_data_t ed, input eieu_resp_t er);
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do @(posedge core_clk); while (arready !== 1'b1);
      arvalid <= 0;
      do @(posedge core_clk); while (rvalid !== 1'b1);
      rready <= 0;
      chk("rdata", ed, rdata);
      chk("rresp", {30'h0, er}, {30'h0, rresp});
   endtask : rd
   // Pin edges need two sync flops plus a compare stage before a flag can move
   task automatic pins(input eieu_line_t v);
      @(posedge core_clk);
      ext_int_pin <= v;
      repeat (6) @(posedge core_clk);
   endtask : pins
   task automatic settle();
      repeat (2) @(posedge core_clk);
      #1;
   endtask : settle
   task automatic t_reset();
      rd(a_flag, 32'h0, `EIEU_RESP_OKAY);
      rd(a_en, 32'h0, `EIEU_RESP_OKAY);
      rd(8'h3c, 32'h0, `EIEU_RESP_SLVERR);
      wr(8'h3c, 32'hff, `EIEU_RESP_SLVERR);
      // Lane 0 strobe low must leave the register untouched
      wstrb <= 4'he;
      wr(a_en, 32'hff, `EIEU_RESP_OKAY);
      wstrb <= 4'hf;
      rd(a_en, 32'h0, `EIEU_RESP_OKAY);
      $display("test reset done");
   endtask : t_reset
   task automatic t_edges();
      wr(a_pol, 32'h0f, `EIEU_RESP_OKAY);
      rd(a_pol, 32'h0f, `EIEU_RESP_OKAY);
      pins(8'hff);
      rd(a_flag, 32'hf0, `EIEU_RESP_OKAY);
      wr(a_flag, 32'h0, `EIEU_RESP_OKAY);
      pins(8'h00);
      rd(a_flag, 32'h0f, `EIEU_RESP_OKAY);
      pins(8'hff);
      pins(8'h00);
      rd(a_flag, 32'hff, `EIEU_RESP_OKAY);
      $display("test edges done");
   endtask : t_edges
   task automatic t_irq();
      settle();
      chk("irq", 32'h0, {31'h0, irq});
      wr(a_mask, 32'hff, `EIEU_RESP_OKAY);
      settle();
      chk("irq", 32'h1, {31'h0, irq});
      rd(a_st, 32'hff, `EIEU_RESP_OKAY);
      settle();
      chk("irq", 32'h0, {31'h0, irq});
      rd(a_st, 32'h0, `EIEU_RESP_OKAY);
      // Status ignores writes; mask reads back
      wr(a_st, 32'hff, `EIEU_RESP_OKAY);
      rd(a_st, 32'h0, `EIEU_RESP_OKAY);
      rd(a_mask, 32'hff, `EIEU_RESP_OKAY);
      $display("test irq done");
   endtask : t_irq
   task automatic t_enable();
      settle();
      chk("req", 32'h0, {31'h0, ext_irq_req});
      wr(a_en, 32'h01, `EIEU_RESP_OKAY);
      repeat (10) @(posedge core_clk);
      #1;
      chk("req", 32'h1, {31'h0, ext_irq_req});
      chk("req_seen", 32'h1, req_seen);
      wr(a_flag, 32'hfe, `EIEU_RESP_OKAY);
      settle();
      chk("req", 32'h0, {31'h0, ext_irq_req});
      wr(a_en, 32'h80, `EIEU_RESP_OKAY);
      settle();
      chk("req", 32'h1, {31'h0, ext_irq_req});
      $display("test enable done");
   endtask : t_enable
   // Second reset with non-zero registers, so the clear is really seen
   task automatic t_rst2();
      @(posedge core_clk);
      rstn <= 0;
      repeat (2) @(posedge core_clk);
      rstn <= 1;
      repeat (2) @(posedge core_clk);
      rd(a_flag, 32'h0, `EIEU_RESP_OKAY);
      rd(a_en, 32'h0, `EIEU_RESP_OKAY);
      rd(a_pol, 32'h0, `EIEU_RESP_OKAY);
      rd(a_mask, 32'h0, `EIEU_RESP_OKAY);
      chk("req", 32'h0, {31'h0, ext_irq_req});
      $display("test mid reset done");
   endtask : t_rst2
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : close_out
   initial
   begin
      repeat (8) @(posedge core_clk);
      rstn <= 1;
      repeat (2) @(posedge core_clk);
      t_reset();
      t_edges();
      t_irq();
      t_enable();
      t_rst2();
      close_out();
   end
   initial
   begin
      repeat (5000) @(posedge core_clk);
      err_total++;
      close_out();
   end
endmodule : external_interrupt_edge_unit_test
`default_nettype wire
